// [rtl/fbwd_pkg.sv]
// Purpose: shared constants and types of the fieldbus watchdog registers
// Assumes: 16-bit register words addressed by word number
// Notes:   all timing is derived from the 25 MHz system clock
`default_nettype none
package fbwd_pkg;

    // ------------------------------------------------------------------
    // register word addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] OFF_UPPER_MASK = 16'h1002;
    localparam logic [15:0] OFF_TRIGGER    = 16'h1003;
    localparam logic [15:0] OFF_MIN_INTVL  = 16'h1004;
    localparam logic [15:0] OFF_STOP_KEY   = 16'h1005;
    localparam logic [15:0] OFF_STATE      = 16'h1006;
    localparam logic [15:0] OFF_RELOAD     = 16'h1007;

    // ------------------------------------------------------------------
    // reset values and key words
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_UPPER_MASK = 16'hffff;
    localparam logic [15:0] RST_TRIGGER    = 16'h0000;
    localparam logic [15:0] RST_MIN_INTVL  = 16'hffff;
    localparam logic [15:0] RST_STOP_KEY   = 16'h0000;
    localparam logic [15:0] RST_RELOAD     = 16'h0001;
    localparam logic [15:0] STOP_KEY_FIRST = 16'haaaa;
    localparam logic [15:0] STOP_KEY_LAST  = 16'h5555;
    localparam logic [15:0] RELOAD_CMD     = 16'h0001;
    localparam logic [15:0] INTVL_MAX      = 16'hffff;
    localparam logic [15:0] FAULT_INTVL    = 16'h0000;

    // ------------------------------------------------------------------
    // status codes and function-code ranges
    // ------------------------------------------------------------------
    localparam logic [15:0] STAT_INACTIVE  = 16'h0000;
    localparam logic [15:0] STAT_RUNNING   = 16'h0001;
    localparam logic [15:0] STAT_EXPIRED   = 16'h0002;
    localparam logic [7:0]  FC_FIRST       = 8'h01;
    localparam logic [7:0]  FC_LOWER_SPAN  = 8'h10;
    localparam logic [7:0]  FC_TOTAL_SPAN  = 8'h20;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned TICK_MS     = 100;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

    typedef enum logic [2:0] {
        st_idle    = 3'b001,
        st_running = 3'b010,
        st_expired = 3'b100
    } fbwd_state_t;

endpackage
`default_nettype wire

// [rtl/fbwd_tick.sv]
// Purpose: prescaler giving one pulse per watchdog time step
// Assumes: clear restarts the step so a reload sees a whole first step
// Notes:   CYCLES of 1 pulses every clock
`timescale 1ns/100ps
`default_nettype none
module fbwd_tick #(
    parameter int unsigned CYCLES = 2
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic clear_i,
    output logic      tick_o
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i || cnt == LAST) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt == LAST);
        end
    end
endmodule
`default_nettype wire

// [rtl/fbwd_regs.sv]
// Purpose: fieldbus watchdog control and status registers with timer
// Assumes: one register access per cycle; timeout and lower mask come
//          from neighbouring registers outside this block
// Notes:   reads answer one cycle after the strobe
// Function
// - upper mask holds codes 17..32 as triggers, all ones after reset
// - upper mask writes ignored unless the watchdog is inactive
// - first nonzero trigger write after reset starts the watchdog if the timeout value is nonzero
// - valid trigger write clears fault and re-enables output writes
// - each trigger keeps the smallest interval seen, reset all ones
// - interval counts in 100 ms steps
// - client write sets stored minimum, no timer effect, zero accepted
// - stop needs 0xaaaa then 0x5555 in the stop-key register
// - completed stop key blocks reaction, clears fault, enables outputs
// - status reads 0 inactive, 1 running, 2 expired, 0 after reset
// - writing 1 to reload register reloads timer; reads 1 after reset
// - reload has no effect once the watchdog has been stopped
// - timeout taken from timeout value in 100 ms steps
// - fieldbus request retriggers only when its mask bit is set
// - minimum interval of zero marks that a fault occurred
`timescale 1ns/100ps
`default_nettype none
module fbwd_regs #(
    parameter int unsigned TICK_CYCLES = fbwd_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register access
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // fieldbus requests
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_fc_i,
    // neighbouring configuration
    input  wire logic [15:0] timeout_value_i,
    input  wire logic [15:0] lower_function_code_mask_i,
    // watchdog outputs
    output logic             fault_o,
    output logic             output_write_en_o,
    output logic             running_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    fbwd_pkg::fbwd_state_t state;
    fbwd_pkg::fbwd_state_t next_state;
    logic [15:0] upper_function_code_mask;
    logic [15:0] alternating_trigger;
    logic [15:0] minimum_trigger_interval;
    logic [15:0] stop_key_sequence;
    logic [15:0] timer_reload;
    logic [15:0] remain;
    logic [15:0] interval;
    logic        key_armed;
    logic        fault;
    logic        tick;

    // ------------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------------
    logic       wr_mask, wr_trig, wr_min, wr_stop, wr_reload;
    logic       trig_new, trig_valid, stop_done, reload_valid;
    logic       fc_sel, fc_hit, kick, expire, take_min, next_fault;
    logic [7:0] fc_idx;

    assign wr_mask   = reg_wr_i && reg_addr_i == fbwd_pkg::OFF_UPPER_MASK;
    assign wr_trig   = reg_wr_i && reg_addr_i == fbwd_pkg::OFF_TRIGGER;
    assign wr_min    = reg_wr_i && reg_addr_i == fbwd_pkg::OFF_MIN_INTVL;
    assign wr_stop   = reg_wr_i && reg_addr_i == fbwd_pkg::OFF_STOP_KEY;
    assign wr_reload = reg_wr_i && reg_addr_i == fbwd_pkg::OFF_RELOAD;

    assign trig_new = wr_trig && reg_wdata_i != alternating_trigger;
    // a start also needs a nonzero timeout, else it would expire at the first step
    assign trig_valid = trig_new && (state != fbwd_pkg::st_idle ||
                        (reg_wdata_i != 16'h0000 &&
                         timeout_value_i != 16'h0000));
    assign stop_done = wr_stop && key_armed &&
                       reg_wdata_i == fbwd_pkg::STOP_KEY_LAST;
    assign reload_valid = wr_reload && state != fbwd_pkg::st_idle &&
                          reg_wdata_i == fbwd_pkg::RELOAD_CMD;

    assign fc_idx = req_fc_i - fbwd_pkg::FC_FIRST;
    always_comb begin
        fc_sel = 1'b0;
        if (req_fc_i >= fbwd_pkg::FC_FIRST) begin
            if (fc_idx < fbwd_pkg::FC_LOWER_SPAN) begin
                fc_sel = lower_function_code_mask_i[fc_idx[3:0]];
            end else if (fc_idx < fbwd_pkg::FC_TOTAL_SPAN) begin
                fc_sel = upper_function_code_mask[fc_idx[3:0]];
            end
        end
    end
    assign fc_hit = req_valid_i && fc_sel &&
                    state == fbwd_pkg::st_running;

    assign kick   = trig_valid || reload_valid || fc_hit;
    // remain of 0 can only come from a zero timeout reload; expire then too
    assign expire = state == fbwd_pkg::st_running && tick && !kick &&
                    remain <= 16'h0001;
    assign take_min = ((trig_valid && state != fbwd_pkg::st_idle) ||
                       fc_hit) && interval < minimum_trigger_interval;

    // ------------------------------------------------------------------
    // step prescaler, restarted on every reload
    // ------------------------------------------------------------------
    fbwd_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (kick),
        .tick_o  (tick)
    );

    // ------------------------------------------------------------------
    // watchdog state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            fbwd_pkg::st_idle: begin
                if (trig_valid) begin
                    next_state = fbwd_pkg::st_running;
                end
            end
            fbwd_pkg::st_running: begin
                if (stop_done) begin
                    next_state = fbwd_pkg::st_idle;
                end else if (expire) begin
                    next_state = fbwd_pkg::st_expired;
                end
            end
            fbwd_pkg::st_expired: begin
                if (stop_done) begin
                    next_state = fbwd_pkg::st_idle;
                end else if (trig_valid || reload_valid) begin
                    next_state = fbwd_pkg::st_running;
                end
            end
            default: begin
                next_state = fbwd_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= fbwd_pkg::st_idle;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // timeout countdown and trigger interval
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remain <= 16'h0000;
        end else if (kick) begin
            remain <= timeout_value_i;
        end else if (tick && state == fbwd_pkg::st_running &&
                     remain != 16'h0000) begin
            remain <= remain - 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || trig_valid || fc_hit) begin
            interval <= 16'h0000;
        end else if (tick && state == fbwd_pkg::st_running &&
                     interval != fbwd_pkg::INTVL_MAX) begin
            interval <= interval + 16'h0001;
        end
    end

    // hardware updates win over a client write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            minimum_trigger_interval <= fbwd_pkg::RST_MIN_INTVL;
        end else if (expire) begin
            minimum_trigger_interval <= fbwd_pkg::FAULT_INTVL;
        end else if (take_min) begin
            minimum_trigger_interval <= interval;
        end else if (wr_min) begin
            minimum_trigger_interval <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // fault and output permission
    // ------------------------------------------------------------------
    always_comb begin
        next_fault = fault;
        if (stop_done) begin
            next_fault = 1'b0;
        end else if (expire) begin
            next_fault = 1'b1;
        end else if (trig_valid) begin
            next_fault = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault             <= 1'b0;
            fault_o           <= 1'b0;
            output_write_en_o <= 1'b1;
            running_o         <= 1'b0;
        end else begin
            fault             <= next_fault;
            fault_o           <= next_fault;
            output_write_en_o <= !next_fault;
            running_o         <= next_state == fbwd_pkg::st_running;
        end
    end

    // ------------------------------------------------------------------
    // client registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upper_function_code_mask <= fbwd_pkg::RST_UPPER_MASK;
        end else if (wr_mask && state == fbwd_pkg::st_idle) begin
            upper_function_code_mask <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alternating_trigger <= fbwd_pkg::RST_TRIGGER;
        end else if (wr_trig) begin
            alternating_trigger <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_key_sequence <= fbwd_pkg::RST_STOP_KEY;
            key_armed         <= 1'b0;
        end else if (wr_stop) begin
            stop_key_sequence <= reg_wdata_i;
            key_armed <= reg_wdata_i == fbwd_pkg::STOP_KEY_FIRST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_reload <= fbwd_pkg::RST_RELOAD;
        end else if (wr_reload) begin
            timer_reload <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o  <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (!reg_rd_i) begin
                reg_rdata_o <= 16'h0000;
            end else begin
                case (reg_addr_i)
                    fbwd_pkg::OFF_UPPER_MASK:
                        reg_rdata_o <= upper_function_code_mask;
                    fbwd_pkg::OFF_TRIGGER:
                        reg_rdata_o <= alternating_trigger;
                    fbwd_pkg::OFF_MIN_INTVL:
                        reg_rdata_o <= minimum_trigger_interval;
                    fbwd_pkg::OFF_STOP_KEY:
                        reg_rdata_o <= stop_key_sequence;
                    fbwd_pkg::OFF_STATE: begin
                        case (state)
                            fbwd_pkg::st_running:
                                reg_rdata_o <= fbwd_pkg::STAT_RUNNING;
                            fbwd_pkg::st_expired:
                                reg_rdata_o <= fbwd_pkg::STAT_EXPIRED;
                            default:
                                reg_rdata_o <= fbwd_pkg::STAT_INACTIVE;
                        endcase
                    end
                    fbwd_pkg::OFF_RELOAD:
                        reg_rdata_o <= timer_reload;
                    default:
                        reg_rdata_o <= 16'h0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [bench/fbwd_client.sv]
// Purpose: register client model facing the watchdog block
// Assumes: strobes change on falling edges, one word per access
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module fbwd_client (
    // clock
    input  wire logic        clk_i,
    // register access
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic      [15:0] reg_addr_o,
    output logic      [15:0] reg_wdata_o,
    input  wire logic [15:0] reg_rdata_i,
    input  wire logic        reg_rvalid_i,
    // fieldbus requests
    output logic             req_valid_o,
    output logic      [7:0]  req_fc_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 16'h0000;
        reg_wdata_o = 16'h0000;
        req_valid_o = 1'b0;
        req_fc_o = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_i);
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    // answer stands one cycle, so it is taken at the falling edge
    task automatic rd(input logic [15:0] a, output logic [15:0] d,
                      output logic v);
        @(negedge clk_i);
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
        v = reg_rvalid_i;
    endtask
    task automatic req(input logic [7:0] fc);
        @(negedge clk_i);
        req_valid_o = 1'b1;
        req_fc_o = fc;
        @(negedge clk_i);
        req_valid_o = 1'b0;
        req_fc_o = ~fc;
    endtask
endmodule
`default_nettype wire

// [bench/fbwd_regs_monitor.sv]
// Purpose: port-level checker of the watchdog registers
// Assumes: one register access per cycle
// Notes:   key arming and last trigger word are tracked in helper flops
`timescale 1ns/100ps
`default_nettype none
module fbwd_regs_monitor (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register access
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic [15:0] reg_rdata_o,
    input  wire logic        reg_rvalid_o,
    // fieldbus and configuration
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_fc_i,
    input  wire logic [15:0] timeout_value_i,
    input  wire logic [15:0] lower_function_code_mask_i,
    // watchdog outputs
    input  wire logic        fault_o,
    input  wire logic        output_write_en_o,
    input  wire logic        running_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic        armed;
    logic [15:0] prev_trig;
    wire         wr_key  = reg_wr_i && reg_addr_i == fbwd_pkg::OFF_STOP_KEY;
    wire         wr_trig = reg_wr_i && reg_addr_i == fbwd_pkg::OFF_TRIGGER;
    wire         idle    = !running_o && !fault_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed <= 1'b0;
        end else if (wr_key) begin
            armed <= reg_wdata_i == fbwd_pkg::STOP_KEY_FIRST;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_trig <= 16'h0000;
        end else if (wr_trig) begin
            prev_trig <= reg_wdata_i;
        end
    end
    // ------------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------------
    sequence s_key_last;
        wr_key && reg_wdata_i == fbwd_pkg::STOP_KEY_LAST;
    endsequence
    sequence s_state_read;
        reg_rd_i && reg_addr_i == fbwd_pkg::OFF_STATE;
    endsequence
    sequence s_new_trig;
        wr_trig && reg_wdata_i != prev_trig;
    endsequence
    AST_RVALID_HI: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    AST_RVALID_LO: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("answer without read");
    AST_RDATA_IDLE: assert property (!reg_rvalid_o |-> reg_rdata_o == 16'h0)
        else $error("read data not zero when idle");
    AST_OUT_EN: assert property (output_write_en_o == !fault_o)
        else $error("output enable not inverse of fault");
    AST_STATE_READ: assert property (s_state_read |=> reg_rdata_o ==
        ($past(running_o) ? fbwd_pkg::STAT_RUNNING : $past(fault_o) ?
         fbwd_pkg::STAT_EXPIRED : fbwd_pkg::STAT_INACTIVE))
        else $error("status code wrong");
    AST_EXPIRY: assert property ($rose(fault_o) |-> $fell(running_o))
        else $error("fault without leaving running");
    AST_START: assert property (idle && timeout_value_i != 16'h0 &&
        reg_wdata_i != 16'h0 ##0 s_new_trig |=> running_o)
        else $error("nonzero trigger did not start");
    AST_FAULT_CLEAR: assert property (fault_o ##0 s_new_trig
        |=> !fault_o && running_o)
        else $error("trigger did not clear fault");
    AST_STOP: assert property (armed ##0 s_key_last
        |=> !running_o && !fault_o)
        else $error("key sequence did not stop");
    AST_KEY_DISARM: assert property (!armed && running_o ##0 s_key_last
        |=> running_o || fault_o)
        else $error("lone second key stopped");
    AST_RELOAD_IDLE: assert property (idle && reg_wr_i &&
        reg_addr_i == fbwd_pkg::OFF_RELOAD |=> !running_o)
        else $error("reload restarted stopped watchdog");
    AST_REQ_IDLE: assert property (idle && req_valid_i |=> !running_o)
        else $error("request started inactive watchdog");
endmodule
bind fbwd_regs fbwd_regs_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .req_valid_i(req_valid_i),
    .req_fc_i(req_fc_i), .timeout_value_i(timeout_value_i),
    .lower_function_code_mask_i(lower_function_code_mask_i),
    .fault_o(fault_o), .output_write_en_o(output_write_en_o),
    .running_o(running_o));
`default_nettype wire

// [bench/fbwd_regs_tb.sv]
// Purpose: self-checking bench of the watchdog registers
// Assumes: time step shortened to 4 cycles, timeout of 3 steps
// Notes:   scenarios run in order and share watchdog state
`timescale 1ns/100ps
`default_nettype none
module fbwd_regs_tb;
    localparam logic [15:0] A_MSK = fbwd_pkg::OFF_UPPER_MASK;
    localparam logic [15:0] A_TRG = fbwd_pkg::OFF_TRIGGER;
    localparam logic [15:0] A_MIN = fbwd_pkg::OFF_MIN_INTVL;
    localparam logic [15:0] A_KEY = fbwd_pkg::OFF_STOP_KEY;
    localparam logic [15:0] A_STA = fbwd_pkg::OFF_STATE;
    localparam logic [15:0] A_RLD = fbwd_pkg::OFF_RELOAD;
    logic clk_i, rst_i, wr, rd, rvalid, req_v, fault, oen, run;
    logic [15:0] addr, wdata, rdata, tmo, lmask;
    logic [7:0] fc;
    int failures = 0;
    int n_checks = 0;
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    fbwd_client client (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata),
        .reg_rvalid_i(rvalid), .req_valid_o(req_v), .req_fc_o(fc));
    fbwd_regs #(.TICK_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .req_valid_i(req_v), .req_fc_i(fc), .timeout_value_i(tmo),
        .lower_function_code_mask_i(lmask), .fault_o(fault),
        .output_write_en_o(oen), .running_o(run));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic flag(input logic f, input logic e);
        chk({15'h0000, f}, {15'h0000, e});
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        v;
        client.rd(a, d, v);
        flag(v, 1'b1);
        chk(d, e);
    endtask
    task automatic wait_fault();
        int i;
        for (i = 0; i < 40 && fault !== 1'b1; i++) @(negedge clk_i);
        if (fault !== 1'b1) begin
            failures++;
            $display("ERROR %0t: watchdog never expired", $time);
            complete_run();
        end
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdchk(A_MSK, 16'hffff);
        rdchk(A_TRG, 16'h0000);
        rdchk(A_MIN, 16'hffff);
        rdchk(A_KEY, 16'h0000);
        rdchk(A_STA, 16'h0000);
        rdchk(A_RLD, 16'h0001);
        rdchk(16'h1008, 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_expire();
        tmo = 16'h0003;
        client.wr(A_MSK, 16'h0001);
        rdchk(A_MSK, 16'h0001);
        client.wr(A_TRG, 16'h0001);
        rdchk(A_STA, 16'h0001);
        client.wr(A_MSK, 16'hffff);
        rdchk(A_MSK, 16'h0001);
        flag(fault, 1'b0);
        wait_fault();
        flag(oen, 1'b0);
        rdchk(A_STA, 16'h0002);
        rdchk(A_MIN, 16'h0000);
        $display("t_expire done");
    endtask
    task automatic t_retrigger();
        client.wr(A_TRG, 16'h0001);
        flag(fault, 1'b1);
        client.wr(A_MIN, 16'hffff);
        rdchk(A_MIN, 16'hffff);
        flag(fault, 1'b1);
        client.wr(A_TRG, 16'h0002);
        flag(fault, 1'b0);
        flag(run, 1'b1);
        repeat (4) @(negedge clk_i);
        client.wr(A_TRG, 16'h0003);
        rdchk(A_MIN, 16'h0001);
        repeat (6) @(negedge clk_i);
        client.wr(A_TRG, 16'h0004);
        rdchk(A_MIN, 16'h0001);
        $display("t_retrigger done");
    endtask
    task automatic t_requests();
        int i;
        lmask = 16'h0010;
        for (i = 0; i < 6; i++) begin
            repeat (5) @(negedge clk_i);
            client.req(i[0] ? 8'h11 : 8'h05);
        end
        flag(run, 1'b1);
        for (i = 0; i < 6; i++) begin
            repeat (3) @(negedge clk_i);
            client.req(i[0] ? 8'h12 : 8'h06);
        end
        flag(fault, 1'b1);
        wait_fault();
        client.wr(A_RLD, 16'h0001);
        flag(run, 1'b1);
        flag(fault, 1'b1);
        $display("t_requests done");
    endtask
    task automatic t_stop();
        int i;
        client.wr(A_KEY, fbwd_pkg::STOP_KEY_FIRST);
        client.wr(A_MIN, 16'h0100);
        client.wr(A_KEY, fbwd_pkg::STOP_KEY_LAST);
        flag(fault, 1'b0);
        flag(oen, 1'b1);
        rdchk(A_STA, 16'h0000);
        client.wr(A_RLD, 16'h0001);
        client.req(8'h05);
        rdchk(A_STA, 16'h0000);
        client.wr(A_TRG, 16'h0000);
        rdchk(A_STA, 16'h0000);
        client.wr(A_TRG, 16'h0005);
        client.wr(A_KEY, fbwd_pkg::STOP_KEY_FIRST);
        client.wr(A_KEY, 16'h1234);
        client.wr(A_KEY, fbwd_pkg::STOP_KEY_LAST);
        flag(run, 1'b1);
        for (i = 0; i < 5; i++) begin
            client.wr(A_RLD, 16'h0001);
            repeat (6) @(negedge clk_i);
        end
        flag(run, 1'b1);
        rdchk(A_RLD, 16'h0001);
        client.wr(A_KEY, fbwd_pkg::STOP_KEY_FIRST);
        client.wr(A_KEY, fbwd_pkg::STOP_KEY_LAST);
        rdchk(A_STA, 16'h0000);
        client.wr(A_MSK, fbwd_pkg::RST_UPPER_MASK);
        rdchk(A_MSK, 16'hffff);
        $display("t_stop done");
    endtask
    initial begin
        rst_i = 1'b1;
        tmo = 16'h0000;
        lmask = 16'hffff;
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_expire();
        t_retrigger();
        t_requests();
        t_stop();
        complete_run();
    end
endmodule
`default_nettype wire
